/* File: hw/flash_host_pkg.sv */
// Constants, codes and carriers for the serial flash host controller.
// Assumes a 50 MHz ref_clk and a flash that samples on rising sclk edges.
package flash_host_pkg;

  // ----------------------------------------------------------------
  // Clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  // Half period of sclk in ref_clk cycles; long enough to cover the
  // four-stage input synchroniser before the next sampling edge
  localparam int SCLK_HALF_CYC = 4;
  localparam int CS_HIGH_NS = 100;
  localparam int CS_HIGH_CYC = (CS_HIGH_NS + CLK_PERIOD_NS - 1) /
                               CLK_PERIOD_NS;
  localparam int PDOWN_ENTRY_NS = 3000;
  localparam int PDOWN_ENTRY_CYC = (PDOWN_ENTRY_NS + CLK_PERIOD_NS - 1) /
                                   CLK_PERIOD_NS;
  localparam int PDOWN_EXIT_NS = 8000;
  localparam int PDOWN_EXIT_CYC = (PDOWN_EXIT_NS + CLK_PERIOD_NS - 1) /
                                  CLK_PERIOD_NS;
  localparam int SIG_DUMMY_CLKS = 24;
  localparam int SECREG_DUMMY_CLKS = 8;
  localparam int DUAL_ID_DUMMY_CLKS = 4;
  localparam int QUAD_ID_DUMMY_CLKS = 6;

  // ----------------------------------------------------------------
  // Flash instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CODE_SECREG_PROGRAM = 8'h42;
  localparam logic [7:0] CODE_SECREG_READ = 8'h48;
  localparam logic [7:0] CODE_DEEP_POWERDOWN = 8'hb9;
  localparam logic [7:0] CODE_RELEASE = 8'hab;
  localparam logic [7:0] CODE_ID_READ = 8'h90;
  localparam logic [7:0] CODE_DUAL_ID_READ = 8'h92;
  localparam logic [7:0] CODE_QUAD_ID_READ = 8'h94;
  localparam logic [7:0] CODE_RESET_ENABLE = 8'h66;
  localparam logic [7:0] CODE_RESET = 8'h99;

  // ----------------------------------------------------------------
  // Operations that software may start
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_SECREG_PROGRAM = 4'h1;
  localparam logic [3:0] OP_SECREG_READ = 4'h2;
  localparam logic [3:0] OP_DEEP_POWERDOWN = 4'h3;
  localparam logic [3:0] OP_RELEASE = 4'h4;
  localparam logic [3:0] OP_SIGNATURE_READ = 4'h5;
  localparam logic [3:0] OP_ID_READ = 4'h6;
  localparam logic [3:0] OP_DUAL_ID_READ = 4'h7;
  localparam logic [3:0] OP_QUAD_ID_READ = 4'h8;
  localparam logic [3:0] OP_SOFT_RESET = 4'h9;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_TX = 8'h0c;
  localparam logic [7:0] REG_RX = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_TX_FULL_BIT = 1;
  localparam int ST_RX_VALID_BIT = 2;
  localparam int ST_POWERED_DOWN_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam logic [10:0] LEN_MAX = 11'h400;
  localparam logic [10:0] LEN_RESET = 11'h001;
  localparam logic [1:0] SEL_RESET = 2'h1;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_CMD = 7'b0000010,
    ST_ADDR = 7'b0000100,
    ST_DUMMY = 7'b0001000,
    ST_WDATA = 7'b0010000,
    ST_RDATA = 7'b0100000,
    ST_GAP = 7'b1000000
  } xfer_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } pin_out_t;

endpackage

/* File: hw/flash_host_ctrl.sv */
// Host controller that drives a serial NOR flash through its pins for
// security register, power-down, signature and identification work.
// Assumes a flash in single-line command mode on cs_n, sclk, io[3:0].
`timescale 1ns/1ps

// How it works
// [R1] Write enable is sent before every program
// [R2] Program: opcode, address, 1 to 1024 bytes
// [R3] Program cycle starts at chip select rise
// [R4] Locked registers ignore program instructions
// [R5] Address upper bits zero, register number, offset
// [R6] Read: opcode, address, dummy byte, data out
// [R7] Read address wraps inside one register
// [R8] Power-down is bare opcode, then entry delay
// [R9] Power-down accepts only release or reset
// [R10] Reset pair leaves power-down
// [R11] Release raises chip select after eighth bit
// [R12] Power cycle ends power-down, standby follows
// [R13] Release from power-down takes exit delay
// [R14] Chip select held high for exit delay
// [R15] Signature repeats while clocks keep coming
// [R16] Release ignored during a program cycle
// [R17] Id read: opcode, zero address, codes out
// [R18] Id codes alternate until chip select rises
// [R19] Dual id read: two lanes, one dummy byte
// [R20] Quad id read: four lanes, three dummy bytes
// [R21] Program end clears busy and write enable
// [R22] Programming only clears bits to zero
// [R23] Program without write enable is ignored
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int PROGRAM_CYCLE_NS = 3000000
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input reg_req_t bus,
  output logic [31:0] reg_rdata,
  input wire logic [3:0] io_in,
  output pin_out_t pins
);

  localparam int PROGRAM_CYCLE_CYC = (PROGRAM_CYCLE_NS + CLK_PERIOD_NS - 1) /
                                     CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Decoding of operations
  // ----------------------------------------------------------------
  function automatic logic [7:0] main_code(input logic [3:0] op);
    case (op)
      OP_SECREG_PROGRAM: main_code = CODE_SECREG_PROGRAM;
      OP_SECREG_READ: main_code = CODE_SECREG_READ;
      OP_DEEP_POWERDOWN: main_code = CODE_DEEP_POWERDOWN;
      OP_RELEASE: main_code = CODE_RELEASE;
      OP_SIGNATURE_READ: main_code = CODE_RELEASE;
      OP_ID_READ: main_code = CODE_ID_READ;
      OP_DUAL_ID_READ: main_code = CODE_DUAL_ID_READ;
      OP_QUAD_ID_READ: main_code = CODE_QUAD_ID_READ;
      OP_SOFT_RESET: main_code = CODE_RESET;
      default: main_code = CODE_NONE;
    endcase
  endfunction

  function automatic logic [7:0] prefix_code(input logic [3:0] op);
    case (op)
      OP_SECREG_PROGRAM: prefix_code = CODE_WRITE_ENABLE; // [R1]
      OP_SOFT_RESET: prefix_code = CODE_RESET_ENABLE; // [R10]
      default: prefix_code = CODE_NONE;
    endcase
  endfunction

  function automatic logic [2:0] op_lanes(input logic [3:0] op);
    case (op)
      OP_DUAL_ID_READ: op_lanes = 3'd2; // [R19]
      OP_QUAD_ID_READ: op_lanes = 3'd4; // [R20]
      default: op_lanes = 3'd1;
    endcase
  endfunction

  function automatic logic [4:0] dummy_clks(input logic [3:0] op);
    case (op)
      OP_SECREG_READ: dummy_clks = 5'(SECREG_DUMMY_CLKS); // [R6]
      OP_SIGNATURE_READ: dummy_clks = 5'(SIG_DUMMY_CLKS);
      OP_DUAL_ID_READ: dummy_clks = 5'(DUAL_ID_DUMMY_CLKS); // [R19]
      OP_QUAD_ID_READ: dummy_clks = 5'(QUAD_ID_DUMMY_CLKS); // [R20]
      default: dummy_clks = 5'd0;
    endcase
  endfunction

  // Opcode alone, chip select rises right after the eighth bit
  function automatic logic is_bare(input logic [3:0] op);
    is_bare = (op == OP_DEEP_POWERDOWN) || (op == OP_RELEASE) ||
              (op == OP_SOFT_RESET); // [R8] [R11]
  endfunction

  function automatic logic has_addr(input logic [3:0] op);
    has_addr = !is_bare(op) && (op != OP_SIGNATURE_READ);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  xfer_state_t state;
  logic [3:0] op;
  logic [2:0] lanes;
  logic prefix;
  logic [23:0] sh;
  logic [4:0] clk_left;
  logic [10:0] bytes_left;
  logic byte_ready;
  logic [23:0] gap_cnt;
  logic powered_down;
  logic refused;
  logic [1:0] secreg_sel;
  logic [9:0] secreg_offset;
  logic [10:0] xfer_len;
  logic tx_valid;
  logic [7:0] tx_data;
  logic rx_valid;
  logic [7:0] rx_data;
  logic [7:0] rx_sh;
  logic [2:0] div_cnt;
  logic sclk;
  logic [3:0] io_s1;
  logic [3:0] io_s2;
  logic [3:0] io_s3;
  logic [3:0] io_stable;
  pin_out_t next_pins;

  logic [2:0] cur_lanes;
  logic shifting;
  logic go;
  logic div_end;
  logic rise;
  logic fall;
  logic unit_last;
  logic tx_take;
  logic rx_done;
  logic end_xfer;
  logic start_req;
  logic start_ok;
  logic [3:0] req_op;
  logic [23:0] post_cyc;
  logic [23:0] addr24;
  logic [4:0] data_clks;

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      io_s3 <= 4'h0;
      io_stable <= 4'h0;
    end else begin
      io_s1 <= io_in;
      io_s2 <= io_s1;
      io_s3 <= io_s2;
      io_stable <= (io_s2 & io_s3) | (io_stable & (io_s2 ^ io_s3));
    end
  end

  // ----------------------------------------------------------------
  // Serial clock
  // ----------------------------------------------------------------
  assign shifting = (state == ST_CMD) || (state == ST_ADDR) ||
                    (state == ST_DUMMY) || (state == ST_WDATA) ||
                    (state == ST_RDATA);
  // Clock stalls low at a byte edge until software feeds or drains
  assign go = shifting &&
              ((state == ST_WDATA) ? byte_ready :
               (state == ST_RDATA) ? !rx_valid : 1'b1);
  assign div_end = (div_cnt == 3'(SCLK_HALF_CYC - 1));
  assign rise = go && !sclk && div_end;
  assign fall = sclk && div_end;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt <= 3'h0;
      sclk <= 1'b0;
    end else begin
      div_cnt <= (div_end || tx_take || !shifting) ? 3'h0 : div_cnt + 3'h1;
      if (rise) begin
        sclk <= 1'b1;
      end else if (fall) begin
        sclk <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencing
  // ----------------------------------------------------------------
  assign cur_lanes = (state == ST_CMD) ? 3'd1 : lanes;
  assign unit_last = (clk_left == 5'd1);
  assign data_clks = (lanes == 3'd4) ? 5'd2 : (lanes == 3'd2) ? 5'd4 : 5'd8;
  assign tx_take = (state == ST_WDATA) && !byte_ready && tx_valid;
  assign rx_done = fall && (state == ST_RDATA) && unit_last;
  assign end_xfer = fall && unit_last &&
    (((state == ST_CMD) && (prefix || is_bare(op))) ||
     (((state == ST_WDATA) || (state == ST_RDATA)) &&
      (bytes_left == 11'd1))); // [R2] [R11] [R15] [R18]
  // Identification reads send a zero address
  assign addr24 = (op == OP_SECREG_READ || op == OP_SECREG_PROGRAM) ?
                  {8'h00, 2'b00, secreg_sel, 2'b00, secreg_offset} :
                  24'h000000; // [R5] [R17] [R19] [R20]
  assign req_op = bus.wdata[3:0];
  assign start_req = bus.wr && (bus.addr == REG_CTRL) &&
                     (state == ST_IDLE);
  assign start_ok = start_req && (main_code(req_op) != CODE_NONE) &&
    (!powered_down || req_op == OP_RELEASE ||
     req_op == OP_SIGNATURE_READ || req_op == OP_SOFT_RESET) && // [R9]
    (xfer_len != 11'd0) && (xfer_len <= LEN_MAX); // [R2]

  always_comb begin
    case (op)
      OP_SECREG_PROGRAM: post_cyc = 24'(PROGRAM_CYCLE_CYC); // [R3] [R21]
      OP_DEEP_POWERDOWN: post_cyc = 24'(PDOWN_ENTRY_CYC); // [R8]
      OP_RELEASE, OP_SIGNATURE_READ, OP_SOFT_RESET:
        post_cyc = powered_down ? 24'(PDOWN_EXIT_CYC) :
                   24'(CS_HIGH_CYC); // [R13] [R14]
      default: post_cyc = 24'(CS_HIGH_CYC);
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      op <= 4'h0;
      lanes <= 3'd1;
      prefix <= 1'b0;
      sh <= 24'h000000;
      clk_left <= 5'd0;
      bytes_left <= 11'd0;
      byte_ready <= 1'b0;
      gap_cnt <= 24'h000000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_ok) begin
            op <= req_op;
            lanes <= op_lanes(req_op);
            bytes_left <= xfer_len;
            prefix <= (prefix_code(req_op) != CODE_NONE);
            sh <= (prefix_code(req_op) != CODE_NONE) ?
                  {prefix_code(req_op), 16'h0000} :
                  {main_code(req_op), 16'h0000};
            clk_left <= 5'd8;
            state <= ST_CMD;
          end
        end
        ST_CMD, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA: begin
          if (tx_take) begin
            sh <= {tx_data, 16'h0000};
            clk_left <= 5'd8;
            byte_ready <= 1'b1;
          end
          if (end_xfer) begin
            state <= ST_GAP;
            // Fixed wait covers the self-timed cycle
            gap_cnt <= prefix ? 24'(CS_HIGH_CYC) : post_cyc; // [R3]
          end else if (fall && unit_last) begin
            case (state)
              ST_CMD: begin
                if (has_addr(op)) begin
                  state <= ST_ADDR;
                  sh <= addr24;
                  clk_left <= 5'd24 / 5'(lanes);
                end else begin
                  state <= ST_DUMMY;
                  clk_left <= dummy_clks(op);
                end
              end
              ST_ADDR: begin
                if (dummy_clks(op) != 5'd0) begin
                  state <= ST_DUMMY;
                  clk_left <= dummy_clks(op);
                end else if (op == OP_SECREG_PROGRAM) begin
                  state <= ST_WDATA;
                  byte_ready <= 1'b0;
                end else begin
                  state <= ST_RDATA;
                  clk_left <= data_clks;
                end
              end
              ST_DUMMY: begin
                state <= ST_RDATA;
                clk_left <= data_clks;
              end
              ST_WDATA: begin
                byte_ready <= 1'b0;
                bytes_left <= bytes_left - 11'd1;
              end
              default: begin
                // Secure register reads keep going; the flash wraps
                clk_left <= data_clks; // [R7]
                bytes_left <= bytes_left - 11'd1;
              end
            endcase
          end else if (fall) begin
            clk_left <= clk_left - 5'd1;
            sh <= sh << cur_lanes;
          end
        end
        ST_GAP: begin
          if (gap_cnt <= 24'h000001) begin
            if (prefix) begin
              prefix <= 1'b0;
              sh <= {main_code(op), 16'h0000};
              clk_left <= 5'd8;
              state <= ST_CMD;
            end else begin
              state <= ST_IDLE;
            end
          end else begin
            gap_cnt <= gap_cnt - 24'h000001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Tracks the flash's power-down state; a host reset assumes standby
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      powered_down <= 1'b0; // [R12]
    end else if (end_xfer && !prefix) begin
      if (op == OP_DEEP_POWERDOWN) begin
        powered_down <= 1'b1; // [R8]
      end else if (op == OP_RELEASE || op == OP_SIGNATURE_READ ||
                   op == OP_SOFT_RESET) begin
        powered_down <= 1'b0; // [R10] [R13]
      end
    end
  end

  // ----------------------------------------------------------------
  // Data bytes between software and the link
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (tx_take) begin
      tx_valid <= 1'b0;
    end else if (bus.wr && bus.addr == REG_TX && !tx_valid) begin
      tx_valid <= 1'b1;
      tx_data <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sh <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      if (fall && state == ST_RDATA) begin
        case (lanes)
          3'd2: rx_sh <= {rx_sh[5:0], io_stable[1:0]}; // [R19]
          3'd4: rx_sh <= {rx_sh[3:0], io_stable}; // [R20]
          default: rx_sh <= {rx_sh[6:0], io_stable[1]}; // [R6] [R17]
        endcase
      end
      // A byte landing in the read cycle is kept: set beats clear
      if (rx_done) begin
        rx_valid <= 1'b1;
        case (lanes)
          3'd2: rx_data <= {rx_sh[5:0], io_stable[1:0]};
          3'd4: rx_data <= {rx_sh[3:0], io_stable};
          default: rx_data <= {rx_sh[6:0], io_stable[1]};
        endcase
      end else if (bus.rd && bus.addr == REG_RX) begin
        rx_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      secreg_sel <= SEL_RESET;
      secreg_offset <= 10'h000;
      xfer_len <= LEN_RESET;
      refused <= 1'b0;
    end else begin
      if (bus.wr && bus.addr == REG_ADDR) begin
        secreg_sel <= bus.wdata[11:10];
        secreg_offset <= bus.wdata[9:0];
      end
      if (bus.wr && bus.addr == REG_LEN) begin
        xfer_len <= bus.wdata[10:0];
      end
      if (start_req && !start_ok) begin
        refused <= 1'b1;
      end else if (bus.wr && bus.addr == REG_STATUS &&
                   bus.wdata[ST_REFUSED_BIT]) begin
        refused <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (bus.rd) begin
      case (bus.addr)
        REG_CTRL: reg_rdata <= {28'h0000000, op};
        REG_ADDR: reg_rdata <= {20'h00000, secreg_sel, secreg_offset};
        REG_LEN: reg_rdata <= {21'h000000, xfer_len};
        REG_TX: reg_rdata <= {24'h000000, tx_data};
        REG_RX: reg_rdata <= {24'h000000, rx_data};
        REG_STATUS: reg_rdata <= {27'h0000000, refused, powered_down,
                                  rx_valid, tx_valid, state != ST_IDLE};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, registered so all pins move together
  // ----------------------------------------------------------------
  always_comb begin
    next_pins.cs_n = !shifting;
    next_pins.sclk = sclk;
    // Write-protect and hold lines sit high unless quad lanes use them
    next_pins.io_out = 4'hc;
    next_pins.io_oe = 4'hc;
    if (lanes == 3'd4 && shifting && state != ST_CMD) begin
      next_pins.io_oe = 4'h0;
    end
    if (state == ST_CMD || state == ST_ADDR || state == ST_WDATA) begin
      case (cur_lanes)
        3'd2: begin
          next_pins.io_out[1:0] = sh[23:22];
          next_pins.io_oe[1:0] = 2'b11;
        end
        3'd4: begin
          next_pins.io_out = sh[23:20];
          next_pins.io_oe = 4'hf;
        end
        default: begin
          next_pins.io_out[0] = sh[23];
          next_pins.io_oe[0] = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins <= '{cs_n: 1'b1, sclk: 1'b0, io_out: 4'h0, io_oe: 4'h0};
    end else begin
      pins <= next_pins;
    end
  end

endmodule

/* File: verification/flash_host_ctrl_assertions.sv */
// Pin-level checker for the flash host controller.
// Assumes mode 0 frames and one command byte per frame on io0.
`timescale 1ns/1ps
module flash_host_ctrl_assertions
  import flash_host_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input reg_req_t bus,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0] io_in,
  input pin_out_t pins
);
  logic cs_n, sclk, sclk_q, pd, wake, fend;
  logic [15:0] rises, hcnt;
  logic [7:0] cmd, last;
  assign cs_n = pins.cs_n;
  assign sclk = pins.sclk;
  assign fend = cs_n && rises != 16'h0;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----------
  // Frame tracking
  // ----------
  // Counts clocks, not bits, so multi-lane frames need no decoding
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
      rises <= 16'h0;
      cmd <= CODE_NONE;
      hcnt <= 16'h0;
      last <= CODE_NONE;
      pd <= 1'b0;
      wake <= 1'b0;
    end else begin
      sclk_q <= sclk;
      rises <= cs_n ? 16'h0 : rises + 16'(sclk && !sclk_q);
      if (!cs_n && sclk && !sclk_q && rises < 16'h8)
        cmd <= {cmd[6:0], pins.io_out[0]};
      hcnt <= cs_n ? hcnt + 16'h1 : 16'h0;
      if (fend) begin
        last <= cmd;
        wake <= pd && (cmd == CODE_RELEASE || cmd == CODE_RESET);
        pd <= cmd == CODE_DEEP_POWERDOWN || pd && cmd == CODE_RESET_ENABLE;
      end
    end
  end
  // ----------
  // Assertions
  // ----------
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("sclk high while deselected");
  a_data_stable: assert property ($rose(sclk) |-> $stable(pins.io_out))
    else $error("data moved at sampling edge");
  a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*5])
    else $error("short deselect");
  a_prog_bytes: assert property (fend && cmd == CODE_SECREG_PROGRAM
    |-> rises[2:0] == 3'h0 && rises >= 16'd40) else $error("bad program");
  a_write_enable_cmd_first: assert property (rises == 16'h8 && !cs_n
    && cmd == CODE_SECREG_PROGRAM |-> last == CODE_WRITE_ENABLE)
    else $error("program without write enable");
  a_reset_pair: assert property (rises == 16'h8 && !cs_n
    && cmd == CODE_RESET |-> last == CODE_RESET_ENABLE)
    else $error("reset without enable");
  a_release_len: assert property (fend && cmd == CODE_RELEASE
    |-> rises == 16'd8 || rises >= 16'd40) else $error("bad release");
  a_entry_gap: assert property ($fell(cs_n) && last == CODE_DEEP_POWERDOWN
    |-> hcnt >= 16'(PDOWN_ENTRY_CYC - 1)) else $error("entry gap");
  a_exit_gap: assert property ($fell(cs_n) && wake
    |-> hcnt >= 16'(PDOWN_EXIT_CYC - 1)) else $error("exit gap");
  c_program: cover property (fend && cmd == CODE_SECREG_PROGRAM);
  c_wake: cover property ($fell(cs_n) && wake);
  c_quad: cover property (rises == 16'h8 && cmd == CODE_QUAD_ID_READ);
endmodule

bind flash_host_ctrl flash_host_ctrl_assertions chk (.ref_clk(ref_clk),
  .arst_n(arst_n), .bus(bus), .reg_rdata(reg_rdata), .io_in(io_in),
  .pins(pins));

/* File: verification/flash_model.sv */
// Behavioural serial flash facing the host controller.
// Assumes single-line command mode and mode 0 clocking.
`timescale 1ns/1ps
module flash_model #(
  parameter logic [7:0] MAKER = 8'hc3,
  parameter logic [7:0] DEV = 8'h17,
  parameter logic [7:0] SIG = 8'h2e,
  parameter int PROG_NS = 1500
) (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_out,
  input wire logic [3:0] h_oe,
  output logic [3:0] io_in
);
  logic [7:0] mem [4][1024];
  logic [7:0] cmd, shf, b;
  logic [23:0] adr;
  logic [7:0] pq[$];
  logic write_enable_latch = 0, write_in_progress_flag = 0, pd = 0, rst_en = 0, oe = 0, tog = 0;
  logic [3:0] drv = 0;
  int n, st, ln, bp, w;
  // Released lines toggle so a stale level never reads as data
  assign io_in = h_oe & h_out | ~h_oe & (oe ? drv : {4{tog}});
  initial foreach (mem[i, j]) mem[i][j] = 8'hff;
  always @(negedge cs_n) n = 0;
  always @(posedge sclk) if (!cs_n) begin
    tog = ~tog;
    if (n < 8) cmd = {cmd[6:0], h_out[0]};
    else if (n < 32) adr = {adr[22:0], h_out[0]};
    else shf = {shf[6:0], h_out[0]};
    if (n >= 32 && n % 8 == 7 && cmd == 8'h42) pq.push_back(shf);
    n++;
  end
  always @(negedge sclk) if (!cs_n) begin
    tog = ~tog;
    st = cmd == 8'h48 ? 40 : cmd inside {8'hab, 8'h90} ? 32 :
      cmd == 8'h92 ? 24 : cmd == 8'h94 ? 20 : 0;
    ln = cmd == 8'h92 ? 2 : cmd == 8'h94 ? 4 : 1;
    if (st > 0 && n >= st && !write_in_progress_flag && !(pd && cmd != 8'hab)) begin
      bp = (n - st) * ln;
      w = 7 - bp % 8;
      b = cmd == 8'h48 ? mem[adr[13:12]][10'(adr[9:0] + bp / 8)] :
        cmd == 8'hab ? SIG : bp / 8 % 2 ? DEV : MAKER;
      drv = ln == 4 ? b[w -: 4] : ln == 2 ? {2'b0, b[w -: 2]} :
        {2'b0, b[w], 1'b0};
      oe = 1;
    end
  end
  always @(posedge cs_n) begin
    oe = 0;
    if (n % 8 == 0 && !write_in_progress_flag && (!pd || cmd inside {8'hab, 8'h66, 8'h99}))
    begin
      case (cmd)
        8'h06: write_enable_latch = 1;
        8'h42: if (write_enable_latch && pq.size() > 0) begin
          foreach (pq[i]) mem[adr[13:12]][10'(adr[9:0] + i)] &= pq[i];
          write_in_progress_flag = 1;
          write_in_progress_flag <= #(PROG_NS) 1'b0;
          write_enable_latch <= #(PROG_NS) 1'b0;
        end
        8'hb9: pd = 1;
        8'hab: if (n == 8 || n >= 40) pd = 0;
        8'h99: if (rst_en) pd = 0;
        default: ;
      endcase
      rst_en = cmd == 8'h66;
    end
    pq.delete();
  end
endmodule

/* File: verification/flash_host_ctrl_tb.sv */
// Self-checking bench for the flash host controller.
// Assumes the flash model on the pins and the checker bound in.
`timescale 1ns/1ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, g, e); \
  end \
end
module flash_host_ctrl_tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'hc3, DEV = 8'h17, SIG = 8'h2e; // Arbitrary
  logic ref_clk = 1'b0, arst_n = 1'b0;
  reg_req_t bus = '0;
  logic [31:0] reg_rdata, d;
  logic [3:0] io_in;
  pin_out_t pins;
  int errors = 0, compares = 0;
  flash_host_ctrl #(.PROGRAM_CYCLE_NS(2000)) dut (.ref_clk(ref_clk),
    .arst_n(arst_n), .bus(bus), .reg_rdata(reg_rdata), .io_in(io_in),
    .pins(pins));
  flash_model #(.MAKER(MAKER), .DEV(DEV), .SIG(SIG)) fm (.cs_n(pins.cs_n),
    .sclk(pins.sclk), .h_out(pins.io_out), .h_oe(pins.io_oe), .io_in(io_in));
  initial forever #10 ref_clk = ~ref_clk;
  // ----------
  // Bus helpers
  // ----------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk) bus <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge ref_clk) bus <= '0;
    #1 d = reg_rdata;
  endtask
  task automatic go(input logic [3:0] op);
    wr(REG_CTRL, {28'h0, op});
  endtask
  // Bounded poll; covers the exit delay
  task automatic wait_st(input int b, input logic v);
    rd(REG_STATUS);
    for (int i = 0; i < 3000 && d[b] !== v; i++) rd(REG_STATUS);
    `CHK(d[b], v)
  endtask
  task automatic rd_op(input logic [3:0] op, input int n,
    input logic [7:0] a, b);
    wr(REG_LEN, 32'(n));
    go(op);
    for (int i = 0; i < n; i++) begin
      wait_st(ST_RX_VALID_BIT, 1'b1);
      rd(REG_RX);
      `CHK(d[7:0], i % 2 ? b : a)
    end
    wait_st(ST_BUSY_BIT, 1'b0);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    rd(REG_STATUS);
    `CHK(d, 32'h0)
  endtask
  task automatic t_program;
    logic [7:0] v[3] = '{8'h5a, 8'ha5, 8'h5a};
    wr(REG_ADDR, {20'h0, 2'h2, 10'h3fe});
    wr(REG_LEN, 32'h3);
    go(OP_SECREG_PROGRAM);
    foreach (v[i]) begin
      wait_st(ST_TX_FULL_BIT, 1'b0);
      wr(REG_TX, {24'h0, v[i]});
    end
    wait_st(ST_BUSY_BIT, 1'b0);
    `CHK(fm.mem[2][10'h3ff], 8'ha5)
    `CHK(fm.mem[2][10'h000], 8'h5a)
    `CHK(fm.write_enable_latch, 1'b0)
  endtask
  task automatic t_reads;
    rd_op(OP_SECREG_READ, 3, 8'h5a, 8'ha5);
    rd_op(OP_ID_READ, 4, MAKER, DEV);
    rd_op(OP_DUAL_ID_READ, 2, MAKER, DEV);
    rd_op(OP_QUAD_ID_READ, 2, MAKER, DEV);
  endtask
  task automatic t_sleep;
    go(OP_DEEP_POWERDOWN);
    wait_st(ST_BUSY_BIT, 1'b0);
    `CHK({fm.pd, d[ST_POWERED_DOWN_BIT]}, 2'b11)
    go(OP_SECREG_READ);
    wait_st(ST_REFUSED_BIT, 1'b1);
    wr(REG_STATUS, 32'h10);
    rd_op(OP_SIGNATURE_READ, 2, SIG, SIG);
    `CHK(fm.pd, 1'b0)
  endtask
  task automatic t_wake;
    logic [3:0] ops[2] = '{OP_RELEASE, OP_SOFT_RESET};
    foreach (ops[i]) begin
      go(OP_DEEP_POWERDOWN);
      wait_st(ST_BUSY_BIT, 1'b0);
      go(ops[i]);
      wait_st(ST_BUSY_BIT, 1'b0);
      `CHK({fm.pd, d[ST_POWERED_DOWN_BIT]}, 2'b00)
    end
  endtask
  task automatic finish_test;
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_program;
    t_reads;
    t_sleep;
    t_wake;
    finish_test;
  end
  initial begin
    #1000000;
    errors++;
    finish_test;
  end
endmodule
